// File: logic/adc_spi_pkg.sv
// shared constants for the converter serial link and its controller
package adc_spi_pkg;
  // config word layout and reset values
  localparam logic [15:0] CFG_RESET = 16'h058B;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int CFG_START_BIT = 15;
  localparam int CFG_INPUT_LSB = 12;
  localparam int CFG_GAIN_LSB = 9;
  localparam int CFG_MODE_BIT = 8;
  localparam int CFG_RATE_LSB = 5;
  localparam int CFG_TEMP_BIT = 4;
  localparam int CFG_PULLUP_BIT = 3;
  localparam int CFG_KEY_LSB = 1;
  localparam int CFG_RSVD_BIT = 0;
  localparam logic [1:0] KEY_VALID = 2'h1;
  // result codes
  localparam int RAW_BITS = 18;
  localparam logic [15:0] CODE_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_MIN = 16'h8000;
  // transfer lengths
  localparam int WORD_BITS = 16;
  localparam int LONG_BITS = 32;
  // serial clock made by the controller
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_HALF_NS = 160;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // controller register map
  localparam logic [7:0] REG_TXCFG = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_READBACK = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_LONG_BIT = 1;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
endpackage

// File: logic/adc_spi_if.sv
// serial link between converter and controller
`timescale 1ns/1ps
`default_nettype none
interface adc_spi_if;
  logic csN;
  logic sclk;
  logic din;
  logic dataOut;
  logic dataOutOeN;
  logic pullupOn;
  wire dataLine;

  // released pin is held high by the weak pullup; a floating pin is
  // modelled as the inverse of the last bit so stale data cannot pass
  assign dataLine = !dataOutOeN ? dataOut : (pullupOn ? 1'b1 : ~dataOut);

  modport device (
    input csN,
    input sclk,
    input din,
    output dataOut,
    output dataOutOeN,
    output pullupOn
  );
  modport host (
    output csN,
    output sclk,
    output din,
    input dataLine
  );
endinterface
`default_nettype wire

// File: logic/adc_serial_device.sv
// converter end: serial shifter, config and result registers, conversion start
`timescale 1ns/1ps
`default_nettype none
module adc_serial_device
  import adc_spi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial link
  adc_spi_if.device link,
  // conversion core
  output logic convStart,
  input wire logic convDone,
  input wire logic signed [RAW_BITS-1:0] convRaw,
  output logic converting,
  // settings for the analog side
  output logic [2:0] inputSelect,
  output logic [2:0] gainRange,
  output logic [2:0] rateSelect,
  output logic tempSenseSelect
);

  function automatic logic [15:0] saturate(input logic signed [RAW_BITS-1:0] raw);
    logic [RAW_BITS-16:0] top;
    top = raw[RAW_BITS-1:15];
    if (top == '0 || top == '1)
      saturate = raw[15:0];
    else if (raw[RAW_BITS-1])
      saturate = CODE_MIN;
    else
      saturate = CODE_MAX;
  endfunction

  // synchronisers; stage 0 feeds only stage 1
  logic [2:0] sclkPipe;
  logic [1:0] csPipe;
  logic [1:0] dinPipe;
  logic sclkRise;
  logic sclkFall;
  logic csHigh;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclkPipe <= 3'h0;
      csPipe <= 2'h3;
      dinPipe <= 2'h0;
    end
    else
    begin
      sclkPipe <= {sclkPipe[1:0], link.sclk};
      csPipe <= {csPipe[0], link.csN};
      dinPipe <= {dinPipe[0], link.din};
    end
  end

  assign csHigh = csPipe[1];
  assign sclkRise = sclkPipe[1] & ~sclkPipe[2];
  assign sclkFall = ~sclkPipe[1] & sclkPipe[2];

  logic [15:0] cfg;
  logic [15:0] result;
  logic [15:0] readback;
  logic [15:0] shiftOut;
  logic [15:0] shiftIn;
  logic [4:0] bitCount;
  logic xferBusy;
  logic newData;
  logic dataOutReg;
  logic oeNReg;
  logic pullupReg;
  logic convStartReg;
  logic convertingReg;

  logic [15:0] next_cfg;
  logic [15:0] next_result;
  logic [15:0] next_readback;
  logic [15:0] next_shiftOut;
  logic [15:0] next_shiftIn;
  logic [4:0] next_bitCount;
  logic next_xferBusy;
  logic next_newData;
  logic next_dataOut;
  logic next_oeN;
  logic next_pullup;
  logic next_convStart;
  logic next_converting;
  logic [15:0] rxWord;
  logic startReq;

  always_comb
  begin
    next_cfg = cfg;
    next_result = result;
    next_readback = readback;
    next_shiftOut = shiftOut;
    next_shiftIn = shiftIn;
    next_bitCount = bitCount;
    next_xferBusy = xferBusy;
    next_newData = newData;
    next_convStart = 1'b0;
    next_converting = convertingReg;
    rxWord = {shiftIn[14:0], dinPipe[1]};
    startReq = 1'b0;
    // idle pin shows the ready flag, low means fresh data
    next_dataOut = xferBusy ? dataOutReg : ~newData;
    next_oeN = csHigh;
    next_pullup = cfg[CFG_PULLUP_BIT];

    // one procedure for both modes, no opcodes
    if (csHigh)
    begin
      next_bitCount = 5'h0;
      next_xferBusy = 1'b0;
    end
    else
    begin
      if (sclkRise)
      begin
        if (!xferBusy)
        begin
          // lock the buffered result, ready flag tells if it is fresh
          next_dataOut = result[15];
          next_shiftOut = {result[14:0], 1'b0};
          next_xferBusy = 1'b1;
          next_newData = 1'b0;
        end
        else if (bitCount == 5'(WORD_BITS))
        begin
          next_dataOut = readback[15];
          next_shiftOut = {readback[14:0], 1'b0};
        end
        else
        begin
          next_dataOut = shiftOut[15];
          next_shiftOut = {shiftOut[14:0], 1'b0};
        end
      end
      if (sclkFall && xferBusy)
      begin
        next_shiftIn = rxWord;
        next_bitCount = bitCount + 5'h1;
        if (bitCount == 5'(WORD_BITS - 1))
        begin
          // start bit never stored, reserved bit forced to one in cfg, echoed as sent in readback
          next_readback = rxWord;
          next_readback[CFG_START_BIT] = 1'b0;
          if (rxWord[CFG_KEY_LSB+1:CFG_KEY_LSB] == KEY_VALID)
          begin
            next_cfg = rxWord;
            next_cfg[CFG_START_BIT] = 1'b0;
            next_cfg[CFG_RSVD_BIT] = 1'b1;
            startReq = rxWord[CFG_START_BIT] & rxWord[CFG_MODE_BIT];
          end
        end
        // with cs tied low a new cycle follows the 32nd bit
        if (bitCount == 5'(LONG_BITS - 1))
        begin
          next_bitCount = 5'h0;
          next_xferBusy = 1'b0;
        end
      end
    end

    // conversion sequencing
    if (convDone)
    begin
      next_result = saturate(convRaw);
      next_newData = 1'b1;
      next_converting = 1'b0;
    end
    if (!convertingReg || convDone)
    begin
      if (!cfg[CFG_MODE_BIT])
        next_convStart = 1'b1;
      else if (startReq)
        next_convStart = 1'b1;
    end
    if (next_convStart)
      next_converting = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg <= CFG_RESET;
      result <= RESULT_RESET;
      readback <= CFG_RESET;
      shiftOut <= 16'h0000;
      shiftIn <= 16'h0000;
      bitCount <= 5'h0;
      xferBusy <= 1'b0;
      newData <= 1'b0;
      dataOutReg <= 1'b1;
      oeNReg <= 1'b1;
      pullupReg <= CFG_RESET[CFG_PULLUP_BIT];
      convStartReg <= 1'b0;
      convertingReg <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      result <= next_result;
      readback <= next_readback;
      shiftOut <= next_shiftOut;
      shiftIn <= next_shiftIn;
      bitCount <= next_bitCount;
      xferBusy <= next_xferBusy;
      newData <= next_newData;
      dataOutReg <= next_dataOut;
      oeNReg <= next_oeN;
      pullupReg <= next_pullup;
      convStartReg <= next_convStart;
      convertingReg <= next_converting;
    end
  end

  // three registers reachable from the link: cfg, result and readback
  assign link.dataOut = dataOutReg;
  assign link.dataOutOeN = oeNReg;
  assign link.pullupOn = pullupReg;
  assign convStart = convStartReg;
  assign converting = convertingReg;
  assign inputSelect = cfg[CFG_INPUT_LSB+2:CFG_INPUT_LSB];
  assign gainRange = cfg[CFG_GAIN_LSB+2:CFG_GAIN_LSB];
  assign rateSelect = cfg[CFG_RATE_LSB+2:CFG_RATE_LSB];
  assign tempSenseSelect = cfg[CFG_TEMP_BIT];

endmodule
`default_nettype wire

// File: logic/adc_serial_host.sv
// controller end: serial master with a small register port for software
`timescale 1ns/1ps
`default_nettype none
module adc_serial_host
  import adc_spi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // software register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // serial link
  adc_spi_if.host link
);

  typedef enum logic [2:0] {
    IDLE = 3'b000,
    LEAD = 3'b001,
    HIGH = 3'b010,
    LOW = 3'b011,
    TRAIL = 3'b100
  } host_state_e;

  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);

  logic [1:0] linePipe;

  always_ff @(posedge clk)
  begin
    if (reset)
      linePipe <= 2'h3;
    else
      linePipe <= {linePipe[0], link.dataLine};
  end

  host_state_e state;
  host_state_e next_state;
  logic [3:0] halfCount;
  logic [3:0] next_halfCount;
  logic [5:0] bitIndex;
  logic [5:0] next_bitIndex;
  logic [31:0] rxShift;
  logic [31:0] next_rxShift;
  logic [15:0] txConfig;
  logic [15:0] next_txConfig;
  logic longMode;
  logic next_longMode;
  logic holdDin;
  logic next_holdDin;
  logic [15:0] rxResult;
  logic [15:0] next_rxResult;
  logic [15:0] rxReadback;
  logic [15:0] next_rxReadback;
  logic csNReg;
  logic next_csN;
  logic sclkReg;
  logic next_sclk;
  logic dinReg;
  logic next_din;
  logic [31:0] next_rdata;
  logic [15:0] txWord;

  always_comb
  begin
    next_state = state;
    next_halfCount = halfCount;
    next_bitIndex = bitIndex;
    next_rxShift = rxShift;
    next_txConfig = txConfig;
    next_longMode = longMode;
    next_holdDin = holdDin;
    next_rxResult = rxResult;
    next_rxReadback = rxReadback;
    next_csN = csNReg;
    next_sclk = sclkReg;
    next_din = dinReg;
    // constant din when no change is wanted, else same word both halves
    txWord = holdDin ? 16'h0000 : txConfig;
    next_rdata = 32'h0000_0000;

    if (regWrite && regAddr == REG_TXCFG)
      next_txConfig = regWdata[15:0];
    if (regRead)
    begin
      case (regAddr)
        REG_TXCFG: next_rdata = {16'h0000, txConfig};
        REG_CTRL: next_rdata = {29'h0, holdDin, longMode, 1'b0};
        REG_STATUS: next_rdata = {30'h0, ~linePipe[1], state != IDLE};
        REG_RESULT: next_rdata = {16'h0000, rxResult};
        REG_READBACK: next_rdata = {16'h0000, rxReadback};
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    case (state)
      IDLE:
      begin
        if (regWrite && regAddr == REG_CTRL && regWdata[CTRL_START_BIT])
        begin
          next_longMode = regWdata[CTRL_LONG_BIT];
          next_holdDin = regWdata[CTRL_HOLD_BIT];
          next_csN = 1'b0;
          next_halfCount = 4'h0;
          next_bitIndex = 6'h0;
          next_state = LEAD;
        end
      end
      LEAD, LOW:
      begin
        next_halfCount = halfCount + 4'h1;
        if (halfCount == HALF_LAST)
        begin
          next_halfCount = 4'h0;
          if (bitIndex == (longMode ? 6'(LONG_BITS) : 6'(WORD_BITS)))
          begin
            next_csN = 1'b1;
            next_state = TRAIL;
          end
          else
          begin
            // din moves on the rise so it is settled by the fall
            next_sclk = 1'b1;
            next_din = txWord[4'hF - bitIndex[3:0]];
            next_state = HIGH;
          end
        end
      end
      HIGH:
      begin
        next_halfCount = halfCount + 4'h1;
        if (halfCount == HALF_LAST)
        begin
          next_halfCount = 4'h0;
          next_rxShift = {rxShift[30:0], linePipe[1]};
          next_sclk = 1'b0;
          next_bitIndex = bitIndex + 6'h1;
          next_state = LOW;
        end
      end
      TRAIL:
      begin
        next_halfCount = halfCount + 4'h1;
        next_din = 1'b0;
        if (halfCount == HALF_LAST)
        begin
          // 32-bit: result then readback; 16-bit: result only
          next_rxResult = longMode ? rxShift[31:16] : rxShift[15:0];
          if (longMode)
            next_rxReadback = rxShift[15:0];
          next_state = IDLE;
        end
      end
      default:
      begin
        next_state = IDLE;
        next_csN = 1'b1;
        next_sclk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= IDLE;
      halfCount <= 4'h0;
      bitIndex <= 6'h0;
      rxShift <= 32'h0000_0000;
      txConfig <= CFG_RESET;
      longMode <= 1'b0;
      holdDin <= 1'b0;
      rxResult <= 16'h0000;
      rxReadback <= 16'h0000;
      csNReg <= 1'b1;
      sclkReg <= 1'b0;
      dinReg <= 1'b0;
      regRdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      halfCount <= next_halfCount;
      bitIndex <= next_bitIndex;
      rxShift <= next_rxShift;
      txConfig <= next_txConfig;
      longMode <= next_longMode;
      holdDin <= next_holdDin;
      rxResult <= next_rxResult;
      rxReadback <= next_rxReadback;
      csNReg <= next_csN;
      sclkReg <= next_sclk;
      dinReg <= next_din;
      regRdata <= next_rdata;
    end
  end

  assign link.csN = csNReg;
  assign link.sclk = sclkReg;
  assign link.din = dinReg;

endmodule
`default_nettype wire

// File: bench/adc_link_checker.sv
// concurrent checks on the converter serial link
`timescale 1ns/1ps
`default_nettype none
module adc_link_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link signals
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  input wire logic dataOut,
  input wire logic dataOutOeN,
  input wire logic pullupOn,
  input wire logic dataLine
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [5:0] riseCnt;

  always_ff @(posedge clk)
  begin
    if (reset || csN)
      riseCnt <= 6'h00;
    else if ($rose(sclk))
      riseCnt <= riseCnt + 6'h01;
  end

  a_cycle_length: assert property ($rose(csN) |-> riseCnt == 6'h10 || riseCnt == 6'h20)
    else $error("transfer length is neither 16 nor 32 clocks");
  a_pin_released: assert property (csN [*4] |-> dataOutOeN)
    else $error("pin still driven while deselected");
  a_pin_driven: assert property ($fell(csN) |-> ##[1:4] !dataOutOeN)
    else $error("pin not driven after select");
  a_weak_pullup: assert property (csN [*4] ##0 pullupOn |-> dataLine)
    else $error("released line not pulled high");
  a_din_settled: assert property ($fell(sclk) |-> $stable(din))
    else $error("din moved at the sampling edge");
  a_bit_holds: assert property ($fell(sclk) && !dataOutOeN |-> $stable(dataOut))
    else $error("output bit moved at the sampling edge");
  a_cfg_on_frame: assert property ($changed(pullupOn) |-> !csN)
    else $error("config changed outside a transfer");
  a_sclk_parked: assert property (csN |-> !sclk)
    else $error("serial clock high while deselected");

  c_short: cover property ($rose(csN) && riseCnt == 6'h10);
  c_long: cover property ($rose(csN) && riseCnt == 6'h20);
  c_pullup_off: cover property ($fell(pullupOn));
endmodule
`default_nettype wire

// File: bench/adc_serial_data_retrieval_bench.sv
// self-checking bench for the converter link pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errTotal++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module adc_serial_data_retrieval_bench;
  import adc_spi_pkg::*;
  logic clk, reset, regWrite, regRead, convDone, convStart, converting, tempSenseSelect;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rnd, cap;
  logic signed [RAW_BITS-1:0] convRaw, nextRaw;
  logic [2:0] inputSelect, gainRange, rateSelect;
  logic [15:0] expRes, devCfg, cfg;
  int errTotal, numChecks, convCnt, starts, i;
  logic signed [RAW_BITS-1:0] corner [4] = '{18'h0_8000, 18'h3_7FFF, 18'h0_7FFF, 18'h3_8000};

  adc_spi_if link();
  adc_serial_device i_adc_serial_device (.clk(clk), .reset(reset), .link(link),
    .convStart(convStart), .convDone(convDone), .convRaw(convRaw), .converting(converting),
    .inputSelect(inputSelect), .gainRange(gainRange), .rateSelect(rateSelect),
    .tempSenseSelect(tempSenseSelect));
  adc_serial_host i_adc_serial_host (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .link(link));
  adc_link_checker i_adc_link_checker (.clk(clk), .reset(reset), .csN(link.csN),
    .sclk(link.sclk), .din(link.din), .dataOut(link.dataOut), .dataOutOeN(link.dataOutOeN),
    .pullupOn(link.pullupOn), .dataLine(link.dataLine));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // taken where the host samples, at the end of the high phase
  always @(negedge link.sclk)
    if (!link.csN)
      cap <= {cap[30:0], link.dataLine};

  // conversion core stand-in: fixed 10-cycle conversion
  always @(posedge clk)
  begin
    convDone <= 1'b0;
    if (convStart)
    begin
      convCnt <= 10;
      starts <= starts + 1;
    end
    else if (convCnt > 0)
      convCnt <= convCnt - 1;
    if (convCnt == 1)
    begin
      convDone <= 1'b1;
      convRaw <= nextRaw;
    end
  end

  function automatic logic [15:0] sat(input logic signed [RAW_BITS-1:0] r);
    if (r > 18'sd32767)
      return CODE_MAX;
    if (r < -18'sd32768)
      return CODE_MIN;
    return r[15:0];
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic run(input logic [15:0] c, input logic lng, input logic hold);
    logic [31:0] d;
    logic [15:0] exp;
    int n;
    exp = expRes;
    n = 0;
    d = 32'h0000_0001;
    wr(REG_TXCFG, {16'h0000, c});
    wr(REG_CTRL, {29'h0000_0000, hold, lng, 1'b1});
    while (d[0] && n < 3000)
    begin
      rd(REG_STATUS, d);
      n++;
    end
    if (n >= 3000)
    begin
      errTotal++;
      $display("Error %0t: transfer never finished", $time);
    end
    if (!hold && c[2:1] == KEY_VALID)
      devCfg = {1'b0, c[14:1], 1'b1};
    if (!hold && c[2:1] == KEY_VALID && (c[15] || !c[8]))
      expRes = sat(nextRaw);
    rd(REG_RESULT, d);
    `CHK(d[15:0], exp)
    `CHK(lng ? cap[31:16] : cap[15:0], exp)
    if (lng)
    begin
      rd(REG_READBACK, d);
      `CHK(d[15:0], hold ? 16'h0000 : {1'b0, c[14:0]})
      `CHK(cap[15:0], hold ? 16'h0000 : {1'b0, c[14:0]})
    end
    `CHK({inputSelect, gainRange}, devCfg[14:9])
    `CHK({rateSelect, tempSenseSelect, link.pullupOn}, devCfg[7:3])
    $display("transfer done cfg %h long %b hold %b", c, lng, hold);
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // about four and a half times the expected run length
  initial
  begin
    #1_000_000;
    errTotal++;
    $display("Error %0t: watchdog expired", $time);
    stopTest();
  end

  initial
  begin
    logic [31:0] d;
    reset = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    nextRaw = 18'h0_0000;
    rnd = 32'h0000_5BC7;
    expRes = RESULT_RESET;
    devCfg = CFG_RESET;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    run(16'h0000, 1'b0, 1'b1);
    for (i = 0; i < 14; i++)
    begin
      rnd = xs(rnd);
      nextRaw = (i < 4) ? corner[i] : rnd[31:14];
      cfg = {1'b1, rnd[14:9], 1'b1, rnd[7:3], ((i < 4 || rnd[2]) ? KEY_VALID : rnd[1:0]), 1'b1};
      run(cfg, rnd[20], 1'b0);
      if (rnd[21])
        run(16'h0000, 1'b1, 1'b1);
    end
    // continuous mode, then back to single shot
    run(16'h048B, 1'b1, 1'b0);
    i = starts;
    repeat (100) @(posedge clk);
    `CHK(starts - i >= 5, 1'b1)
    run(16'h058B, 1'b0, 1'b0);
    i = starts;
    run(16'h0000, 1'b0, 1'b1);
    `CHK(starts == i, 1'b1)
    `CHK(converting, 1'b0)
    rd(8'hFC, d);
    `CHK(d, 32'h0000_0000)
    stopTest();
  end
endmodule
`default_nettype wire
